// ### fimr_pkg.sv
package fimr_pkg;

  // ==========================================================
  // control register numbers on the core's register port
  // ==========================================================
  localparam logic [4:0] REG_FAULT_ADDR   = 5'h07;
  localparam logic [4:0] REG_SETUP        = 5'h0d;
  localparam logic [4:0] REG_REGION_SEL   = 5'h0e;
  localparam logic [4:0] REG_REGION_ATTR  = 5'h0f;

  // ==========================================================
  // field positions and widths
  // ==========================================================
  localparam int unsigned PROT_ON_POS     = 0;
  localparam int unsigned REGION_D_POS    = 0;
  localparam int unsigned INDEX_LSB       = 1;
  localparam int unsigned INDEX_W         = 5;
  localparam int unsigned BASE_LSB        = 6;
  localparam int unsigned BASE_W          = 25;
  localparam int unsigned ATTR_WR_POS     = 0;
  localparam int unsigned ATTR_RD_POS     = 1;
  localparam int unsigned CACHE_BYPASS_POS = 31;
  localparam int unsigned MIN_REGION_LOG2 = 6;

  // ==========================================================
  // reset values
  // ==========================================================
  localparam logic [31:0] FAULT_ADDR_RST  = 32'h0000_0000;
  localparam logic [31:0] SETUP_RST       = 32'h0000_0000;
  localparam logic [31:0] REGION_SEL_RST  = 32'h0000_0000;

  // ==========================================================
  // exception cause codes presented by the core
  // ==========================================================
  typedef enum logic [3:0] {
    CAUSE_OTHER        = 4'h0,
    CAUSE_SUPV_INSTR   = 4'h1,
    CAUSE_SUPV_DATA    = 4'h2,
    CAUSE_MISALIGN_DATA = 4'h3,
    CAUSE_MISALIGN_DEST = 4'h4,
    CAUSE_FAST_MISS_D  = 4'h5,
    CAUSE_DBL_MISS_D   = 4'h6,
    CAUSE_PERM_RD      = 4'h7,
    CAUSE_PERM_WR      = 4'h8,
    CAUSE_PERM_X       = 4'h9,
    CAUSE_FAST_MISS_I  = 4'ha,
    CAUSE_BREAK        = 4'hb
  } fimr_cause_t;

  typedef struct packed {
    logic        take;
    fimr_cause_t cause;
    logic        has_addr;
    logic        is_data;
    logic [31:0] addr;
  } fimr_exc_t;

  typedef struct packed {
    logic        bad_vaddr;
    logic        perm_viol;
    logic        data_access;
  } fimr_flags_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        is_data;
    logic [4:0]  index;
    logic [24:0] base;
  } fimr_region_op_t;

endpackage

// ### fimr_fault_region.sv
`timescale 1ns/1ns
module fimr_fault_region #(
  parameter bit          HAS_MMU        = 1'b0,
  parameter bit          HAS_MPU        = 1'b1,
  parameter bit          EXTRA_INFO_OPT = 1'b1,
  parameter int unsigned ADDR_W         = 32,
  parameter int unsigned MIN_REGION_SZ  = 64,
  parameter int unsigned NUM_REGIONS    = 32
) (
  // clock and reset
  input  wire logic                      CLK_SYS,
  input  wire logic                      RST_N,
  input  wire logic                      CLK_EN,
  // exception report from the core
  input  wire fimr_pkg::fimr_exc_t       EXC,
  // control register port
  input  wire logic                      REG_WR,
  input  wire logic                      REG_RD,
  input  wire logic [4:0]                REG_NUM,
  input  wire logic [31:0]               REG_WDATA,
  output logic      [31:0]               REG_RDATA,
  // status and region operation toward the protection unit
  output fimr_pkg::fimr_flags_t          FLAGS,
  output logic                           PROT_ON,
  output fimr_pkg::fimr_region_op_t      REGION_OP
);

  // ==========================================================
  // build-time masks
  // ==========================================================
  localparam bit EXTRA_INFO = HAS_MMU || HAS_MPU || EXTRA_INFO_OPT;
  localparam int unsigned FA_W = (HAS_MMU || HAS_MPU) ? 32 : ADDR_W;
  localparam logic [31:0] FA_MASK = (FA_W >= 32) ? 32'hffff_ffff
                                  : ((32'h0000_0001 << FA_W) - 32'h0000_0001);
  // base bits below the minimum region or above the address space stay zero
  localparam int unsigned LOW_ZERO = $clog2(MIN_REGION_SZ) - fimr_pkg::MIN_REGION_LOG2;
  localparam int unsigned HI_KEEP  = (ADDR_W < 31) ? ADDR_W - fimr_pkg::BASE_LSB
                                                   : fimr_pkg::BASE_W;
  localparam logic [24:0] BASE_MASK =
    ((25'h1ffffff >> (fimr_pkg::BASE_W - HI_KEEP)) >> LOW_ZERO) << LOW_ZERO;
  localparam logic [4:0] INDEX_MASK =
    5'(((32'h0000_0001 << $clog2(NUM_REGIONS)) - 32'h0000_0001));

  // ==========================================================
  // state
  // ==========================================================
  // exception side
  fimr_pkg::fimr_flags_t     flags_q, flags_d;
  logic [31:0]               fault_q, fault_d;

  // software-written setup and region select
  logic                      prot_q, prot_d;
  logic [24:0]               base_q, base_d;
  logic [4:0]                index_q, index_d;
  logic                      rtype_q, rtype_d;

  // answers toward the protection unit and the core
  fimr_pkg::fimr_region_op_t op_q, op_d;
  logic [31:0]               rdata_q, rdata_d;

  // ==========================================================
  // exception capture
  // ==========================================================
  logic        is_bad;
  logic        is_perm;
  logic        is_data;
  logic        fault_load;
  logic [31:0] cap_addr;

  // bad address causes
  always_comb begin
    unique case (EXC.cause)
      fimr_pkg::CAUSE_SUPV_INSTR,
      fimr_pkg::CAUSE_SUPV_DATA,
      fimr_pkg::CAUSE_MISALIGN_DATA,
      fimr_pkg::CAUSE_MISALIGN_DEST: is_bad = 1'b1;
      default:                       is_bad = 1'b0;
    endcase
  end

  // permission causes, execute included
  always_comb begin
    unique case (EXC.cause)
      fimr_pkg::CAUSE_PERM_RD,
      fimr_pkg::CAUSE_PERM_WR,
      fimr_pkg::CAUSE_PERM_X:        is_perm = 1'b1;
      default:                       is_perm = 1'b0;
    endcase
  end

  // data-side causes; execute and instruction misses stay out
  always_comb begin
    unique case (EXC.cause)
      fimr_pkg::CAUSE_FAST_MISS_D,
      fimr_pkg::CAUSE_DBL_MISS_D,
      fimr_pkg::CAUSE_PERM_RD,
      fimr_pkg::CAUSE_PERM_WR,
      fimr_pkg::CAUSE_MISALIGN_DATA,
      fimr_pkg::CAUSE_SUPV_DATA:     is_data = 1'b1;
      default:                       is_data = 1'b0;
    endcase
  end

  // ==========================================================
  // captured address, one bit at a time
  // ==========================================================
  for (genvar b = 0; b < 32; b++) begin : g_cap
    if (b == fimr_pkg::CACHE_BYPASS_POS && !HAS_MMU) begin : g_bypass
      // cache-bypass bit, never part of a data fault address here
      assign cap_addr[b] = FA_MASK[b] & EXC.addr[b] & !EXC.is_data;
    end else begin : g_plain
      assign cap_addr[b] = FA_MASK[b] & EXC.addr[b];
    end
  end

  // ==========================================================
  // cause flags
  // ==========================================================
  always_comb begin
    flags_d = flags_q;
    if (EXC.take) begin
      // all three together, except the origin bit on a break, so software never sees a mixed set
      flags_d.bad_vaddr = is_bad;
      flags_d.perm_viol = is_perm;
      // a break leaves the origin bit as it was
      if (EXC.cause != fimr_pkg::CAUSE_BREAK) begin
        flags_d.data_access = is_data;
      end
    end
  end

  // ==========================================================
  // fault address
  // ==========================================================
  // causes without an address leave the previous one for software
  assign fault_load = EXC.take && EXTRA_INFO && EXC.has_addr;

  always_comb begin
    fault_d = fault_q;
    if (fault_load) begin
      fault_d = cap_addr;
    end
  end

  // ==========================================================
  // runtime setup
  // ==========================================================
  always_comb begin
    prot_d = prot_q;
    if (REG_WR && REG_NUM == fimr_pkg::REG_SETUP) begin
      // tied low when no protection unit is built
      prot_d = HAS_MPU & REG_WDATA[fimr_pkg::PROT_ON_POS];
    end
  end

  // ==========================================================
  // region select
  // ==========================================================
  always_comb begin
    base_d  = base_q;
    index_d = index_q;
    rtype_d = rtype_q;
    if (HAS_MPU && REG_WR && REG_NUM == fimr_pkg::REG_REGION_SEL) begin
      // masked bits are dropped on the way in, so reads give zero
      base_d  = REG_WDATA[fimr_pkg::BASE_LSB +: fimr_pkg::BASE_W] & BASE_MASK;
      index_d = REG_WDATA[fimr_pkg::INDEX_LSB +: fimr_pkg::INDEX_W] & INDEX_MASK;
      rtype_d = REG_WDATA[fimr_pkg::REGION_D_POS];
    end
  end

  // ==========================================================
  // region operation pulse
  // ==========================================================
  always_comb begin
    // one-cycle request; the attribute word itself lives elsewhere
    op_d = '0;
    if (HAS_MPU && REG_WR && REG_NUM == fimr_pkg::REG_REGION_ATTR) begin
      op_d.rd      = REG_WDATA[fimr_pkg::ATTR_RD_POS];
      op_d.wr      = REG_WDATA[fimr_pkg::ATTR_WR_POS];
      op_d.is_data = rtype_q;
      op_d.index   = index_q;
      op_d.base    = base_q;
    end
  end

  // ==========================================================
  // read data
  // ==========================================================
  always_comb begin
    // answers for one cycle only, zero otherwise
    rdata_d = '0;
    if (REG_RD) begin
      unique case (REG_NUM)
        fimr_pkg::REG_FAULT_ADDR: rdata_d = fault_q;
        fimr_pkg::REG_SETUP: begin
          rdata_d[fimr_pkg::PROT_ON_POS] = prot_q;
        end
        fimr_pkg::REG_REGION_SEL: begin
          rdata_d[fimr_pkg::BASE_LSB +: fimr_pkg::BASE_W]   = base_q;
          rdata_d[fimr_pkg::INDEX_LSB +: fimr_pkg::INDEX_W] = index_q;
          rdata_d[fimr_pkg::REGION_D_POS]                   = rtype_q;
        end
        default: rdata_d = '0;
      endcase
    end
  end

  // ==========================================================
  // cause flag register
  // ==========================================================
  // clock enable low freezes every register, pulses included
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      flags_q <= '0;
    end else if (CLK_EN) begin
      flags_q <= flags_d;
    end
  end

  // ==========================================================
  // fault address register
  // ==========================================================
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      fault_q <= fimr_pkg::FAULT_ADDR_RST;
    end else if (CLK_EN) begin
      fault_q <= fault_d;
    end
  end

  // ==========================================================
  // setup register
  // ==========================================================
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      prot_q <= fimr_pkg::SETUP_RST[fimr_pkg::PROT_ON_POS];
    end else if (CLK_EN) begin
      prot_q <= prot_d;
    end
  end

  // ==========================================================
  // region select registers
  // ==========================================================
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      base_q  <= fimr_pkg::REGION_SEL_RST[fimr_pkg::BASE_LSB +: fimr_pkg::BASE_W];
      index_q <= fimr_pkg::REGION_SEL_RST[fimr_pkg::INDEX_LSB +: fimr_pkg::INDEX_W];
      rtype_q <= fimr_pkg::REGION_SEL_RST[fimr_pkg::REGION_D_POS];
    end else if (CLK_EN) begin
      base_q  <= base_d;
      index_q <= index_d;
      rtype_q <= rtype_d;
    end
  end

  // ==========================================================
  // region operation register
  // ==========================================================
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      op_q <= '0;
    end else if (CLK_EN) begin
      op_q <= op_d;
    end
  end

  // ==========================================================
  // read data register
  // ==========================================================
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= '0;
    end else if (CLK_EN) begin
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  assign REG_RDATA = rdata_q;
  assign FLAGS     = flags_q;
  assign PROT_ON   = prot_q;
  assign REGION_OP = op_q;

endmodule // fimr_fault_region

// ### fimr_fault_region_chk.sv
`timescale 1ns/1ns
module fimr_chk (
  // clock and reset
  input wire logic                      CLK_SYS,
  input wire logic                      RST_N,
  input wire logic                      CLK_EN,
  // core side
  input wire fimr_pkg::fimr_exc_t       EXC,
  input wire logic                      REG_WR,
  input wire logic                      REG_RD,
  input wire logic [4:0]                REG_NUM,
  input wire logic [31:0]               REG_WDATA,
  input wire logic [31:0]               REG_RDATA,
  // outputs
  input wire fimr_pkg::fimr_flags_t     FLAGS,
  input wire logic                      PROT_ON,
  input wire fimr_pkg::fimr_region_op_t REGION_OP
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  // ==========================================================
  // sequences
  sequence s_wr(logic [4:0] num);
    CLK_EN && REG_WR && REG_NUM == num;
  endsequence
  // instruction fault followed by a read of the captured address
  sequence s_cap;
    CLK_EN && EXC.take && EXC.has_addr && !EXC.is_data
    ##1 CLK_EN && REG_RD && REG_NUM == 5'h07 && !EXC.take;
  endsequence
  // ==========================================================
  // assertions
  a_bad_flag: assert property (CLK_EN && EXC.take |=> FLAGS.bad_vaddr ==
    ($past(EXC.cause) inside {4'h1, 4'h2, 4'h3, 4'h4})) else $error("bad address flag wrong");
  a_perm_flag: assert property (CLK_EN && EXC.take |=> FLAGS.perm_viol ==
    ($past(EXC.cause) inside {4'h7, 4'h8, 4'h9})) else $error("permission flag wrong");
  a_data_flag: assert property (CLK_EN && EXC.take && EXC.cause != 4'hb |=>
    FLAGS.data_access == ($past(EXC.cause) inside {4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8}))
    else $error("data origin flag wrong");
  a_data_brk: assert property (CLK_EN && EXC.take && EXC.cause == 4'hb |=>
    $stable(FLAGS.data_access)) else $error("break changed data origin flag");
  a_flags_hold: assert property (CLK_EN && !EXC.take |=> $stable(FLAGS))
    else $error("flags moved without exception");
  a_prot_on: assert property (s_wr(5'h0d) |=> PROT_ON == $past(REG_WDATA[0]))
    else $error("protection enable not written");
  a_op_pulse: assert property (s_wr(5'h0f) |=> REGION_OP.rd == $past(REG_WDATA[1])
    && REGION_OP.wr == $past(REG_WDATA[0])) else $error("region op pulse wrong");
  a_op_idle: assert property (CLK_EN && !(REG_WR && REG_NUM == 5'h0f) |=>
    !REGION_OP.rd && !REGION_OP.wr) else $error("spurious region op");
  a_rdata_idle: assert property (CLK_EN && !REG_RD |=> REG_RDATA == 32'h0)
    else $error("read data without read");
  a_setup_res: assert property (CLK_EN && REG_RD && REG_NUM == 5'h0d |=>
    REG_RDATA[31:1] == 31'h0) else $error("setup reserved bits set");
  a_fault_cap: assert property (s_cap |=> REG_RDATA == $past(EXC.addr, 2))
    else $error("fault address not captured");
  a_freeze_hold: assert property (!CLK_EN |=> $stable(FLAGS) && $stable(PROT_ON) &&
    $stable(REGION_OP) && $stable(REG_RDATA)) else $error("state moved while frozen");
endmodule // fimr_chk

bind fimr_fault_region fimr_chk fimr_chk_inst (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
  .CLK_EN(CLK_EN), .EXC(EXC), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_NUM(REG_NUM),
  .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .FLAGS(FLAGS), .PROT_ON(PROT_ON),
  .REGION_OP(REGION_OP));

// ### test_fimr_fault_region.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("FAIL %s exp %h got %h", nm, e, g); end end
module test_fimr_fault_region;
  // ==========================================================
  // signals and model state
  logic                      CLK_SYS = 1'b0;
  logic                      RST_N, CLK_EN, REG_WR, REG_RD, PROT_ON;
  logic [4:0]                REG_NUM;
  logic [31:0]               REG_WDATA, REG_RDATA;
  fimr_pkg::fimr_exc_t       EXC;
  fimr_pkg::fimr_flags_t     FLAGS;
  fimr_pkg::fimr_region_op_t REGION_OP;
  // 8 regions, 256 byte minimum, 28 address bits
  localparam logic [31:0]    SEL_MASK = 32'h0fff_ff0f;
  logic [2:0]                m_flags = 3'h0;
  logic [31:0]               m_fa = 32'h0, m_sel = 32'h0, seed = 32'h0000_004c;
  logic [31:0]               m_rd = 32'h0;
  logic [32:0]               m_op = 33'h0;
  logic [4:0]                nums [5] = '{5'h07, 5'h0d, 5'h0e, 5'h0f, 5'h13};
  logic                      m_pe = 1'b0;
  int                        n_errors = 0, n_checks = 0, cycles = 0;
  fimr_fault_region #(.HAS_MPU(1'b1), .EXTRA_INFO_OPT(1'b1), .ADDR_W(28),
    .MIN_REGION_SZ(256), .NUM_REGIONS(8)) fimr_fault_region_inst (.CLK_SYS(CLK_SYS),
    .RST_N(RST_N), .CLK_EN(CLK_EN), .EXC(EXC), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_NUM(REG_NUM), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .FLAGS(FLAGS),
    .PROT_ON(PROT_ON), .REGION_OP(REGION_OP));
  always #5 CLK_SYS = ~CLK_SYS;
  // ==========================================================
  // helpers
  function automatic logic [31:0] nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // one cycle of stimulus; model advanced, then every output compared
  task automatic cyc(input logic w, r, input logic [4:0] n, input logic [31:0] d,
                     input logic t, input logic [3:0] c, input logic ha, isd,
                     input logic [31:0] a);
    REG_WR = w;
    REG_RD = r;
    REG_NUM = n;
    REG_WDATA = d;
    EXC = {t, c, ha, isd, a};
    // a frozen cycle keeps every model value, pulses included
    if (CLK_EN) begin
      m_rd = !r ? 32'h0 : n == 5'h07 ? m_fa : n == 5'h0d ? {31'h0, m_pe} :
             n == 5'h0e ? m_sel : 32'h0;
      m_op = 33'h0;
      if (w && n == 5'h0d) m_pe = d[0];
      if (w && n == 5'h0e) m_sel = d & SEL_MASK;
      if (w && n == 5'h0f) m_op = {d[1], d[0], m_sel[0], m_sel[5:1], m_sel[30:6]};
      if (t) begin
        m_flags[2] = c inside {4'h1, 4'h2, 4'h3, 4'h4};
        m_flags[1] = c inside {4'h7, 4'h8, 4'h9};
        if (c != 4'hb) m_flags[0] = c inside {4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8};
        if (ha) m_fa = isd ? {1'b0, a[30:0]} : a;
      end
    end
    @(posedge CLK_SYS);
    #1;
    `CHK("rdata", m_rd, REG_RDATA)
    `CHK("flags", m_flags, FLAGS)
    `CHK("prot_on", m_pe, PROT_ON)
    `CHK("region_op", m_op, REGION_OP)
  endtask
  // ==========================================================
  // run
  always @(posedge CLK_SYS) begin
    cycles++;
    if (cycles > 2000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    logic [31:0] r;
    RST_N = 1'b0;
    CLK_EN = 1'b1;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_NUM = 5'h00;
    REG_WDATA = 32'h0;
    EXC = '0;
    repeat (12) @(posedge CLK_SYS);
    #1 RST_N = 1'b1;
    // reset values, and every register number read once
    for (int n = 0; n < 32; n++) begin
      cyc(1'h0, 1'h1, n[4:0], 32'h0, 1'h0, 4'h0, 1'h0, 1'h0, 32'h0);
    end
    // each cause, then its captured address read back
    for (int c = 0; c < 12; c++) begin
      r = nxt();
      cyc(1'h0, 1'h0, 5'h00, 32'h0, 1'h1, c[3:0], 1'h1, r[0], nxt());
      cyc(1'h0, 1'h1, 5'h07, 32'h0, 1'h0, 4'h0, 1'h0, 1'h0, 32'h0);
    end
    // data fault then break: origin flag must survive the break
    cyc(1'h0, 1'h0, 5'h00, 32'h0, 1'h1, 4'h3, 1'h1, 1'h1, 32'hffff_fffd);
    cyc(1'h0, 1'h0, 5'h00, 32'h0, 1'h1, 4'hb, 1'h0, 1'h0, 32'h0);
    // random back-to-back traffic, clock enable dropped now and then
    for (int i = 0; i < 300; i++) begin
      r = nxt();
      CLK_EN = r[15:12] != 4'h0;
      cyc(r[0], !r[0] && r[1], nums[r[4:2] % 5], nxt(), r[5], 4'(r[11:8] % 12), r[6],
          r[7], nxt());
    end
    stop_test();
  end
endmodule // test_fimr_fault_region
